// ==== hdl/bsc_decode.sv ====
// Purpose: combinational opcode recogniser
// Assumes: 12-bit instruction word
// Notes:   pure decode, no state
`timescale 1ns/1ps
`default_nettype none
module bsc_decode (
    input  wire logic [11:0] instr_i,
    output logic             is_skip_o,
    output logic             is_call_o,
    output logic             is_clear_file_reg_op_o,
    output logic [2:0]       bit_idx_o,
    output logic [4:0]       reg_addr_o,
    output logic [7:0]       imm_o
);
    import bsc_pkg::*;
    always_comb begin
        is_skip_o  = (instr_i[11:8] == BSC_OP_SKIP_SET);
        is_call_o  = (instr_i[11:8] == BSC_OP_CALL);
        is_clear_file_reg_op_o  = (instr_i[11:5] == BSC_OP_CLEAR_FILE_REG_OP);
        bit_idx_o  = instr_i[7:5];
        reg_addr_o = instr_i[4:0];
        imm_o      = instr_i[7:0];
    end
endmodule // bsc_decode
`default_nettype wire

// ==== hdl/bsc_exec.sv ====
// Purpose: executes bit-test-skip-if-set, call and clear-register
// Assumes: register file read is combinational on rf_raddr_o
// Notes:   other opcodes advance the counter by one
`timescale 1ns/1ps
`default_nettype none
module bsc_exec (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        instr_valid_i,
    input  wire logic [11:0] instr_i,
    input  wire logic [7:0]  rf_rdata_i,
    input  wire logic [7:0]  status_i,
    output logic [4:0]       rf_raddr_o,
    output logic             rf_we_o,
    output logic [4:0]       rf_waddr_o,
    output logic [7:0]       rf_wdata_o,
    output logic             zero_set_o,
    output logic             push_o,
    output logic [bsc_pkg::BSC_PC_W-1:0] push_addr_o,
    output logic [bsc_pkg::BSC_PC_W-1:0] pc_o,
    output logic             flush_o,
    output logic             busy_o
);
    import bsc_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic       is_skip;
    logic       is_call;
    logic       is_clear_file_reg_op;
    logic [2:0] bit_idx;
    logic [4:0] reg_addr;
    logic [7:0] imm;

    bsc_decode u_dec (
        .instr_i    (instr_i),
        .is_skip_o  (is_skip),
        .is_call_o  (is_call),
        .is_clear_file_reg_op_o  (is_clear_file_reg_op),
        .bit_idx_o  (bit_idx),
        .reg_addr_o (reg_addr),
        .imm_o      (imm)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        bsc_state_t          st;
        logic [BSC_PC_W-1:0] pc;
        logic                we;
        logic [4:0]          waddr;
        logic [7:0]          wdata;
        logic                zset;
        logic                push;
        logic [BSC_PC_W-1:0] paddr;
    } bsc_regs_t;

    bsc_regs_t s_q;
    bsc_regs_t s_d;
    logic      in_flush;

    assign rf_raddr_o = reg_addr;
    assign in_flush   = (s_q.st == BSC_ST_FLUSH);
    assign flush_o    = in_flush;
    assign busy_o     = in_flush;

    always_comb begin
        s_d       = s_q;
        s_d.we    = 1'b0;
        s_d.zset  = 1'b0;
        s_d.push  = 1'b0;
        unique case (s_q.st)
            BSC_ST_FLUSH: begin
                // prefetched word dropped, executes as a no-operation
                s_d.st = BSC_ST_EXEC;
                if (instr_valid_i) begin
                    s_d.pc = s_q.pc + 11'h001;
                end
            end
            BSC_ST_EXEC: begin
                if (instr_valid_i) begin
                    s_d.pc = s_q.pc + 11'h001;
                    if (is_skip && rf_rdata_i[bit_idx]) begin
                        s_d.st = BSC_ST_FLUSH;
                    end
                    if (is_call) begin
                        s_d.push  = 1'b1;
                        s_d.paddr = s_q.pc + 11'h001;
                        s_d.pc    = {status_i[BSC_STAT_PA_HI:BSC_STAT_PA_LO], 1'b0, imm};
                        s_d.st    = BSC_ST_FLUSH;
                    end
                    if (is_clear_file_reg_op) begin
                        s_d.we    = 1'b1;
                        s_d.waddr = reg_addr;
                        s_d.wdata = BSC_ZERO_B;
                        s_d.zset  = 1'b1;
                    end
                end
            end
        endcase
        if (!resetn_i) begin
            s_d       = '0;
            s_d.st    = BSC_ST_EXEC;
            s_d.pc    = BSC_PC_RST;
            s_d.wdata = BSC_ZERO_B;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        s_q <= s_d;
    end

    assign rf_we_o     = s_q.we;
    assign rf_waddr_o  = s_q.waddr;
    assign rf_wdata_o  = s_q.wdata;
    assign zero_set_o  = s_q.zset;
    assign push_o      = s_q.push;
    assign push_addr_o = s_q.paddr;
    assign pc_o        = s_q.pc;

endmodule // bsc_exec
`default_nettype wire

// ==== hdl/bsc_pkg.sv ====
// Purpose: constants and types for the skip / call / clear instruction executor
// Assumes: one core instruction cycle per sys_clk_i edge
// Notes:   12-bit instruction words, 8-bit data, 11-bit program counter
//
// Functional notes
// - an opcode with top nibble 0111 carries bit index and register address, and skips when that bit is one.
// - a skip discards the prefetched instruction and runs a no-operation in its place, so the test takes two cycles.
// - a call has top nibble 1001 and loads its 8-bit immediate into counter bits 7 to 0.
// - a call first pushes the counter plus one onto the return stack as its new top.
// - a call copies status bits 6 and 5 to counter bits 10 and 9 and forces counter bit 8 to zero.
// - a call always takes two cycles by flushing the prefetch and changes no status flag.
// - the clear-register opcode writes 00h to register 0 to 31 and sets the zero flag as its only status effect.
package bsc_pkg;

    // --------------------------------------------------------------
    // encodings
    // --------------------------------------------------------------
    localparam logic [3:0] BSC_OP_SKIP_SET = 4'h7;
    localparam logic [3:0] BSC_OP_CALL     = 4'h9;
    localparam logic [6:0] BSC_OP_CLEAR_FILE_REG_OP     = 7'h03;  // 0000 011f ffff, top 7 bits
    localparam logic [11:0] BSC_NOP_WORD   = 12'h000;

    // --------------------------------------------------------------
    // field positions and widths
    // --------------------------------------------------------------
    localparam int BSC_PC_W       = 11;
    localparam int BSC_STAT_PA_HI = 6;
    localparam int BSC_STAT_PA_LO = 5;
    localparam int BSC_STAT_Z     = 2;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [10:0] BSC_PC_RST  = 11'h7FF;
    localparam logic [7:0]  BSC_ZERO_B  = 8'h00;

    typedef enum logic [1:0] {
        BSC_ST_EXEC  = 2'b01,
        BSC_ST_FLUSH = 2'b10
    } bsc_state_t;

endpackage

// ==== test/bit_skip_call_clear_exec_tb.sv ====
// Purpose: bench; Assumes: one word per cycle; Notes: skips use regs 0-15, clears 16-31
`timescale 1ns/1ps
`default_nettype none
module bit_skip_call_clear_exec_tb;
    import bsc_pkg::*;
    logic        sys_clk_i = 0, resetn_i = 0, instr_valid_i = 0, ld_i = 0, vd = 0, fl = 0;
    logic        rf_we_o, zero_set_o, push_o, flush_o, busy_o;
    logic [11:0] instr_i = 12'h000;
    logic [7:0]  status_i = 8'h00, rf_rdata_i, rf_wdata_o, rf [16];
    logic [4:0]  rf_raddr_o, rf_waddr_o;
    logic [10:0] push_addr_o, pc_o, pc = BSC_PC_RST;
    logic [38:0] q [$];
    logic [38:0] ev;
    int          n_fail = 0, num_checks = 0;
    initial forever #5 sys_clk_i = ~sys_clk_i;
    bsc_exec bsc_exec_inst (.*);
    bsc_rf bsc_rf_inst (.clk_i(sys_clk_i), .we_i(rf_we_o), .ld_i(ld_i), .ra_i(rf_raddr_o),
        .wa_i(rf_waddr_o), .wd_i(rf_wdata_o), .ld_d_i(status_i), .rd_o(rf_rdata_i));
    task automatic print_verdict;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [38:0] seen, input logic [38:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: outputs after word", $time);
        end
    endtask
    task automatic step(input logic [11:0] w, input logic [7:0] st);
        logic [38:0] e;
        @(posedge sys_clk_i);
        {ld_i, instr_valid_i, instr_i, status_i} <= {2'b01, w, st};
        e = {pc + 11'h1, 28'h0};
        if (fl) fl = 1'b0;
        else if (w[11:8] == BSC_OP_SKIP_SET) begin
            fl = rf[w[3:0]][w[7:5]];
            e[27] = fl;
        end else if (w[11:8] == BSC_OP_CALL) begin
            e = {st[6:5], 1'b0, w[7:0], 4'hC, pc + 11'h1, 13'h0};
            fl = 1'b1;
        end else if (w[11:5] == BSC_OP_CLEAR_FILE_REG_OP) e[25:8] = {2'b11, 11'h0, w[4:0]};
        pc = e[38:28];
        q.push_back(e);
    endtask
    always @(posedge sys_clk_i) vd <= instr_valid_i && resetn_i;
    always @(negedge sys_clk_i) if (vd) begin
        ev = q.pop_front();
        check({pc_o, flush_o, push_o, rf_we_o, zero_set_o, push_o ? push_addr_o : 11'h0, rf_we_o ? {rf_waddr_o, rf_wdata_o} : 13'h0}, ev);
        check({38'h0, busy_o}, {38'h0, ev[27]});
    end
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [7:0] r;
        void'($urandom(32'h5E4B));
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk_i);
            rf[i] = i ? 8'($urandom) : 8'h81;
            {ld_i, instr_i, status_i} <= {1'b1, 12'(i), rf[i]};
        end
        step(12'h9FF, 8'h60);
        step(12'h071, 8'h00);
        step(12'h7E0, 8'h00);
        step(12'h700, 8'h00);
        step(12'h720, 8'h00);
        step(12'h070, 8'h9F);
        step(12'h900, 8'hBF);
        step(12'h7E0, 8'h00);
        $display("directed done");
        for (int i = 0; i < 300; i++) begin
            r = 8'($urandom);
            case ($urandom_range(3))
                0: step({4'h7, r[7:5], 1'b0, r[3:0]}, 8'($urandom));
                1: step({4'h9, r}, 8'($urandom));
                2: step({7'h03, 1'b1, r[3:0]}, 8'($urandom));
                default: step({4'h2, r}, 8'($urandom));
            endcase
        end
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        $display("random done");
        print_verdict();
    end
endmodule // bit_skip_call_clear_exec_tb
`default_nettype wire

// ==== test/bsc_rf.sv ====
// Purpose: register file partner; Assumes: async read; Notes: loads through ra_i
`timescale 1ns/1ps
`default_nettype none
module bsc_rf (
    input  wire logic       clk_i, we_i, ld_i,
    input  wire logic [4:0] ra_i, wa_i,
    input  wire logic [7:0] wd_i, ld_d_i,
    output logic      [7:0] rd_o
);
    logic [7:0] mem [32];
    assign rd_o = mem[ra_i];
    always @(posedge clk_i) begin
        if (we_i) mem[wa_i] <= wd_i;
        else if (ld_i) mem[ra_i] <= ld_d_i;
    end
endmodule // bsc_rf
`default_nettype wire

// ==== test/bsc_sva.sv ====
// Purpose: port checker; Assumes: rf read combinational; Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module bsc_sva (
    input wire logic        sys_clk_i, resetn_i, instr_valid_i, rf_we_o, zero_set_o, push_o, flush_o,
    input wire logic [11:0] instr_i,
    input wire logic [7:0]  rf_rdata_i, status_i, rf_wdata_o,
    input wire logic [4:0]  rf_waddr_o,
    input wire logic [bsc_pkg::BSC_PC_W-1:0] push_addr_o, pc_o
);
    import bsc_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic tk = instr_valid_i && !flush_o;
    wire logic sk = tk && instr_i[11:8] == BSC_OP_SKIP_SET;
    wire logic hit = rf_rdata_i[instr_i[7:5]];
    wire logic cl = tk && instr_i[11:8] == BSC_OP_CALL;
    wire logic cr = tk && instr_i[11:5] == BSC_OP_CLEAR_FILE_REG_OP;
    skip_taken_a: assert property (sk && hit |=> flush_o) else $error("skip");
    skip_pass_a: assert property (sk && !hit |=> !flush_o && !zero_set_o) else $error("pass");
    call_pc_a: assert property (cl |=> pc_o == {$past(status_i[6:5]), 1'b0, $past(instr_i[7:0])})
        else $error("call pc");
    call_push_a: assert property (cl |=> push_o && push_addr_o == $past(pc_o) + 11'h1) else $error("push");
    call_cycles_a: assert property (cl |=> flush_o && !zero_set_o ##1 !flush_o) else $error("cycles");
    clear_reg_a: assert property (cr |=> rf_we_o && zero_set_o && rf_wdata_o == 8'h00
        && rf_waddr_o == $past(instr_i[4:0])) else $error("clear");
    discard_a: assert property (flush_o |=> !rf_we_o && !push_o) else $error("discard");
    zero_only_a: assert property (!cr |=> !zero_set_o) else $error("zero");
    cover property (sk && hit);
    cover property (cl);
    cover property (cr);
endmodule // bsc_sva
bind bsc_exec bsc_sva bsc_sva_inst (.*);
`default_nettype wire
